//--- include/phy_status_pkg.sv
package phy_status_pkg;
  localparam logic [4:0]  addr_basic_status     = 5'h01;
  localparam logic [4:0]  addr_identifier_high  = 5'h02;
  localparam logic [4:0]  addr_identifier_low   = 5'h03;
  localparam logic [4:0]  addr_partner_ability  = 5'h05;
  // Status and partner ability bit positions
  localparam int          bit_t4                = 15;
  localparam int          bit_tx_fd             = 14;
  localparam int          bit_tx_hd             = 13;
  localparam int          bit_10_fd             = 12;
  localparam int          bit_10_hd             = 11;
  localparam int          bit_rsvd_hi           = 10;
  localparam int          bit_rsvd_lo           = 7;
  localparam int          bit_short_frame       = 6;
  localparam int          bit_an_done           = 5;
  localparam int          bit_rem_fault         = 4;
  localparam int          bit_an_able           = 3;
  localparam int          bit_link              = 2;
  localparam int          bit_jabber            = 1;
  localparam int          bit_ext_cap           = 0;
  localparam int          bit_partner_fault     = 13;
  // Fixed status values
  localparam logic        t4_capable            = 1'b0;
  localparam logic        mode_capable          = 1'b1;
  localparam logic        rsvd_value            = 1'b0;
  localparam logic        short_frame_accept    = 1'b1;
  localparam logic        an_capable            = 1'b1;
  localparam logic        ext_capable           = 1'b1;
  // Identifier field layout
  localparam int          id_org_hi_msb         = 15;
  localparam int          id_org_lo_lsb         = 10;
  localparam int          id_model_lsb          = 4;
  localparam logic [15:0] zero_word             = 16'h0000;
endpackage : phy_status_pkg

//--- verilog/phy_basic_status_and_id_regs.sv
// Summary of operation
// - Status bit 15, 100BASE-T4 capability, always reads zero.
// - Status bits 14 to 11, TX and 10BASE-T duplex abilities, always read one.
// - Reserved status bits 10 to 7 read zero; writes to them are ignored.
// - Preamble suppression bit reads one; frames without preamble are accepted.
// - Negotiation-complete bit follows finished auto-negotiation; zero after reset.
// - Remote fault bit latches high until status read or chip reset.
// - Remote fault sets after partner fault flag, partner ability bit 13, sets.
// - Auto-negotiation ability bit always reads one.
// - Link status reads one with a valid 10 or 100 link; zero after reset.
// - Link status latches low on failure until the register is read.
// - Jabber bit latches high until status read or chip reset.
// - Jabber detected only at 10 Mbps; at 100 Mbps a status read clears it.
// - Extended capability bit always reads one.
// - First identifier holds org identifier bits 3 to 18 in bits 15 to 0.
// - Both identifier registers form one read-only org, model, revision identifier.
// - Second identifier: org bits 19-24, model in 9-4, revision in 3-0.
// - Partner fault flag sets when the partner signals remote fault in negotiation.
`timescale 1ns/10ps
module phy_basic_status_and_id_regs #(
  parameter logic [23:0] org_id   = 24'h00_1234, // Arbitrary value
  parameter logic [5:0]  model_id = 6'h05,       // Arbitrary value
  parameter logic [3:0]  revision = 4'h1         // Arbitrary value
) (
  input  wire logic                     clk,            // 20 MHz clock
  input  wire logic                     rst,            // Sync reset, high
  input  wire logic                     rd_strobe,      // Register read request
  input  wire logic [4:0]               rd_addr,        // Register address
  input  wire logic                     wr_strobe,      // Register write request
  input  wire logic [4:0]               wr_addr,        // Write address
  input  wire logic [15:0]              wr_data,        // Write data
  input  wire logic                     an_complete_in, // Negotiation finished
  input  wire logic                     link_ok_in,     // Valid link present
  input  wire logic                     speed_10_in,    // Running at 10 Mbps
  input  wire logic                     jabber_in,      // Jabber condition
  input  wire logic                     partner_rf_in,  // Partner remote fault seen
  output logic [15:0]                   rd_data,        // Read data
  output logic                          rd_valid,       // Read data valid pulse
  output logic                          partner_fault_flag // Partner ability bit 13
);
  import phy_status_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0]  an_sync;
    logic [1:0]  link_sync;
    logic [1:0]  spd_sync;
    logic [1:0]  jab_sync;
    logic [1:0]  rf_sync;
    logic        an_done;
    logic        rem_fault;
    logic        link_latched;
    logic        jabber;
    logic        partner_fault_flag;
    logic [15:0] rd_data;
    logic        rd_valid;
  } state_s;

  state_s cur;
  state_s nxt;

  // Organisation identifier slices: bit 1 of the identifier is org_id[23]
  localparam int org_upper_msb = 21;
  localparam int org_upper_lsb = 6;
  localparam int org_lower_msb = 5;

  // Identifier words built once from the parameters
  function automatic logic [15:0] id_word(input logic hi);
    logic [15:0] w;
    w = zero_word;
    if (hi) begin
      w = org_id[org_upper_msb:org_upper_lsb];
    end else begin
      w[id_org_hi_msb:id_org_lo_lsb] = org_id[org_lower_msb:0];
      w[id_org_lo_lsb-1:id_model_lsb] = model_id;
      w[id_model_lsb-1:0] = revision;
    end
    return w;
  endfunction : id_word

  function automatic logic [15:0] status_word(input state_s s);
    logic [15:0] w;
    w = zero_word;
    w[bit_t4]          = t4_capable;
    w[bit_tx_fd]       = mode_capable;
    w[bit_tx_hd]       = mode_capable;
    w[bit_10_fd]       = mode_capable;
    w[bit_10_hd]       = mode_capable;
    w[bit_rsvd_hi:bit_rsvd_lo] = {4{rsvd_value}};
    w[bit_short_frame] = short_frame_accept;
    w[bit_an_done]     = s.an_done;
    w[bit_rem_fault]   = s.rem_fault;
    w[bit_an_able]     = an_capable;
    w[bit_link]        = s.link_latched;
    w[bit_jabber]      = s.jabber;
    w[bit_ext_cap]     = ext_capable;
    return w;
  endfunction : status_word

  ////////////////////////////////////////////////////////////////////////////////
  logic status_read;
  assign status_read = rd_strobe && (rd_addr == addr_basic_status);

  always_comb begin
    nxt = cur;
    nxt.an_sync   = {cur.an_sync[0], an_complete_in};
    nxt.link_sync = {cur.link_sync[0], link_ok_in};
    nxt.spd_sync  = {cur.spd_sync[0], speed_10_in};
    nxt.jab_sync  = {cur.jab_sync[0], jabber_in};
    nxt.rf_sync   = {cur.rf_sync[0], partner_rf_in};
    nxt.rd_valid  = rd_strobe;
    nxt.an_done   = cur.an_sync[1];
    // Partner flag is sticky within the negotiation result
    if (cur.rf_sync[1]) begin
      nxt.partner_fault_flag = 1'b1;
    end else if (!cur.an_sync[1]) begin
      nxt.partner_fault_flag = 1'b0;
    end
    // Read releases latches to live value; a live event on that cycle still wins
    if (status_read) begin
      nxt.rem_fault    = cur.partner_fault_flag;
      nxt.link_latched = cur.link_sync[1];
      nxt.jabber       = cur.jab_sync[1] && cur.spd_sync[1];
    end else begin
      if (cur.partner_fault_flag) begin
        nxt.rem_fault = 1'b1;
      end
      if (!cur.link_sync[1]) begin
        nxt.link_latched = 1'b0;
      end
      if (cur.jab_sync[1] && cur.spd_sync[1]) begin
        nxt.jabber = 1'b1;
      end
    end
    // Every register here is read-only; writes change nothing
    if (rd_strobe) begin
      case (rd_addr)
        addr_basic_status:    nxt.rd_data = status_word(cur);
        addr_identifier_high: nxt.rd_data = id_word(1'b1);
        addr_identifier_low:  nxt.rd_data = id_word(1'b0);
        addr_partner_ability: begin
          nxt.rd_data = zero_word;
          nxt.rd_data[bit_partner_fault] = cur.partner_fault_flag;
        end
        default:              nxt.rd_data = zero_word;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign rd_data            = cur.rd_data;
  assign rd_valid           = cur.rd_valid;
  assign partner_fault_flag = cur.partner_fault_flag;
endmodule : phy_basic_status_and_id_regs

//--- testbench/phy_status_properties.sv
`timescale 1ns/10ps
module phy_status_properties import phy_status_pkg::*;
  #(parameter logic [23:0] org_id = 24'h00_1234) (
  input wire logic clk, rst, rd_strobe, rd_valid, // Clock, reset, read handshake
  input wire logic [4:0] rd_addr, input wire logic [15:0] rd_data); // Read address and data
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic st = rd_strobe && rd_addr == addr_basic_status;
  valid_pulse_a: assert property (rd_strobe |=> rd_valid) else $error("no valid");
  stray_valid_a: assert property (!rd_strobe |=> !rd_valid) else $error("stray valid");
  hold_data_a: assert property (!rd_strobe |=> $stable(rd_data)) else $error("data moved");
  caps_fixed_a: assert property (st |=> rd_data[15:11] == 5'h0F) else $error("caps");
  rsvd_zero_a: assert property (st |=> rd_data[10:7] == 4'h0) else $error("reserved");
  fixed_ones_a: assert property (st |=> (rd_data & 16'h0049) == 16'h0049) else $error("ones");
  id_high_a: assert property (rd_strobe && rd_addr == addr_identifier_high |=> rd_data == org_id[21:6]) else $error("id");
  reset_clear_a: assert property ($fell(rst) |-> rd_data == 16'h0000 && !rd_valid) else $error("reset");
  cover property (st ##1 rd_data[2]);
  cover property (st ##1 rd_data[1]);
  cover property (st ##1 rd_data[4]);
endmodule : phy_status_properties

//--- testbench/mgmt_station_model.sv
`timescale 1ns/10ps
module mgmt_station_model (
  input wire logic clk, go, input wire logic [4:0] addr, // Clock, start, register
  output logic rd_strobe = 1'b0, output logic [4:0] rd_addr = 5'h00); // Request lines
  always @(posedge clk) rd_strobe <= go; // One-cycle request
  // Idle address toggles so a stale value is never mistaken for a request
  always @(posedge clk) rd_addr <= go ? addr : ~rd_addr;
endmodule : mgmt_station_model

//--- testbench/phy_basic_status_and_id_regs_tb.sv
`timescale 1ns/10ps
module phy_basic_status_and_id_regs_tb;
  import phy_status_pkg::*;
  localparam logic [23:0] org_id = 24'h00_A5C3; // Arbitrary value
  localparam logic [5:0]  model_id = 6'h05;     // Arbitrary value
  localparam logic [3:0]  revision = 4'h1;      // Arbitrary value
  logic        clk = 1'b0, rst = 1'b1, go = 1'b0, wr_strobe = 1'b0, rd_strobe, rd_valid, pff;
  logic [4:0]  live = 5'h00, addr = 5'h01, rd_addr;
  logic [15:0] rd_data, wr_data = 16'hFFFF;
  int          fail_count = 0, cmp_count = 0;
  phy_basic_status_and_id_regs #(.org_id(org_id), .model_id(model_id), .revision(revision))
    i_dut (.clk(clk), .rst(rst), .rd_addr(rd_addr),
    .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .wr_addr(addr), .wr_data(wr_data),
    .an_complete_in(live[4]), .link_ok_in(live[3]), .speed_10_in(live[2]), .jabber_in(live[1]),
    .partner_rf_in(live[0]), .rd_data(rd_data), .rd_valid(rd_valid), .partner_fault_flag(pff));
  mgmt_station_model i_stn (.clk(clk), .go(go), .addr(addr), .rd_strobe(rd_strobe), .rd_addr(rd_addr));
  initial forever #25 clk = ~clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    fail_count += int'(seen !== exp);
    if (seen !== exp)
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
  endtask : check
  task automatic rd(input logic [15:0] exp, input logic [4:0] a = addr_basic_status);
    @(posedge clk) go <= 1'b1;
    addr <= a;
    @(posedge clk) go <= 1'b0;
    for (int i = 0; i < 8 && rd_valid !== 1'b1; i++) @(posedge clk);
    check({15'h0000, rd_valid}, 16'h0001);
    check(rd_data, exp);
  endtask : rd
  task automatic t_fixed();
    wr_strobe <= 1'b1;
    @(posedge clk) wr_strobe <= 1'b0;
    rd(16'h7849);
    rd(org_id[21:6], addr_identifier_high);
    rd({org_id[5:0], model_id, revision}, addr_identifier_low);
  endtask : t_fixed
  // Each step holds the inputs six cycles, past sync and latch delay
  task automatic t_latch();
    repeat (6) @(posedge clk) live <= 5'b01000;
    rd(16'h7849);
    repeat (6) @(posedge clk) live <= 5'b00000;
    repeat (6) @(posedge clk) live <= 5'b01010;
    repeat (6) @(posedge clk) live <= 5'b01000;
    rd(16'h7849);
    repeat (6) @(posedge clk) live <= 5'b11111;
    repeat (6) @(posedge clk) live <= 5'b11100;
    rd(16'h787F);
    rd(16'h2000, addr_partner_ability);
    check({15'h0000, pff}, 16'h0001);
    repeat (6) @(posedge clk) live <= 5'b01100;
    check({15'h0000, pff}, 16'h0000);
    rd(16'h785D);
    rd(16'h784D);
  endtask : t_latch
  task automatic test_done(input int hang);
    fail_count += hang;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_fixed();
    t_latch();
    test_done(0);
  end
  initial #100000 test_done(1); // Hang guard, about twenty-five times the run
endmodule : phy_basic_status_and_id_regs_tb
bind phy_basic_status_and_id_regs phy_status_properties #(.org_id(org_id)) i_props (.clk(clk),
  .rst(rst), .rd_strobe(rd_strobe), .rd_valid(rd_valid), .rd_addr(rd_addr), .rd_data(rd_data));
